// >>> cedt_can_node.sv
module cedt_can_node (
  // device pins
  input  wire logic i_tx_pin,
  output logic      o_rx_pin,
  // bus conditions chosen by the test
  input  wire logic i_tx_inv,
  input  wire logic i_rx_inv,
  input  wire logic i_other_dom
);
  timeunit 1ns;
  timeprecision 1ps;

  logic bus_level;

  // wired-and bus: any dominant node wins, so a receiver sees the other node too
  assign bus_level = (i_tx_pin ^ i_tx_inv) & ~i_other_dom;
  // transceiver echoes the bus back, inverted when the pin is wired that way
  assign o_rx_pin  = bus_level ^ i_rx_inv;
endmodule

// >>> cedt_core.sv
// Behaviour
// RULE1 - error counter register: receive count in upper byte, transmit count lower.
// RULE2 - read-only diagnostic register of last error, zero after reset.
// RULE3 - diag layout: rsvd, drive, monitor, crc, stuff, transmitter, position, field.
// RULE4 - field codes 0000..0111: flag, delimiter, echo, idle, ack, eof, intermission, suspend.
// RULE5 - field codes 1000..1111: sof, arbitration, ide, ext arb, r1/r0, dlc, data, crc.
// RULE6 - position counter loads field length minus one, decrements per bit, captured.
// RULE7 - transmitter flag shows whether device was transmitting at error.
// RULE8 - stuff flag set on bit-stuffing violation.
// RULE9 - crc flag set on invalid checksum; meaningful with ack field code.
// RULE10 - monitor bit captures sampled receive pin level at error.
// RULE11 - drive bit captures driven transmit pin level at error.
// RULE12 - as receiver drive dominant only in ack slot or active error flag.
// RULE13 - free-running 16-bit stamp counter increments per recognised bit.
// RULE14 - stamp counter starts from zero after reset.
// RULE15 - with clear enable set, buffer 0 transfer clears stamp counter.
// RULE16 - successful frame copies stamp count to message buffer stamp.
// RULE17 - software configures timing, buffers, masks before setting enable.
// RULE18 - software checks no transmission pending before disabling.
// RULE19 - disabling controller also disables receive input.
// RULE20 - configuration keeps contents through low power; software re-enables.
// RULE21 - separate polarity bits for transmit and receive pins.
// RULE22 - any error counter change sets pending flag; enable gates interrupt.
// RULE23 - stamp counter wraps from maximum to zero and keeps counting.
// RULE24 - error counters follow can fault-confinement rules.
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
module cedt_core (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  // avalon-mm slave
  input  wire logic [7:0]            i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [31:0]           i_avs_writedata,
  input  wire logic [3:0]            i_avs_byteenable,
  output logic      [31:0]           o_avs_readdata,
  output logic                       o_avs_waitrequest,
  // frame engine events
  input  wire logic                  i_bit_tick,
  input  wire logic                  i_field_start,
  input  wire logic [6:0]            i_field_len,
  input  wire logic                  i_err_event,
  input  wire cedt_pkg::cedt_err_type i_err_info,
  input  wire logic                  i_transmitting,
  input  wire logic                  i_tx_bit,
  input  wire logic                  i_ack_slot,
  input  wire logic                  i_active_err_flag,
  input  wire logic                  i_tx_ok,
  input  wire logic                  i_rx_ok,
  input  wire logic                  i_buf0_xfer,
  // engine side results
  output logic                       o_rx_bit,
  output logic                       o_ctrl_enable,
  output logic                       o_bus_off,
  output logic                       o_stamp_we,
  output logic      [15:0]           o_stamp_data,
  output logic                       o_err_irq,
  // can pins
  input  wire logic                  i_bus_rx_pin,
  output logic                       o_bus_tx_pin
);

  cedt_pkg::cedt_bus_type  bus_state_ff;
  cedt_pkg::cedt_gcfg_type gcfg_ff;
  cedt_pkg::cedt_diag_type diag_ff;
  logic [7:0]              tec_ff;
  logic [7:0]              rec_ff;
  logic [7:0]              nxt_tec;
  logic [7:0]              nxt_rec;
  logic                    nxt_bus_off;
  logic                    bus_off_ff;
  logic [15:0]             stamp_ff;
  logic [5:0]              pos_ff;
  logic                    error_interrupt_pending_ff;
  logic                    error_interrupt_enable_ff;
  logic                    rx_meta_ff;
  logic                    rx_sync_ff;
  logic                    tx_pin_ff;
  logic                    nxt_tx_logic;
  logic                    stamp_we_ff;
  logic [15:0]             stamp_data_ff;
  logic [31:0]             rdata_ff;
  logic                    req;
  logic                    wr_take;
  logic                    eiclr;
  logic                    en;

  // register hit decode, shared by read mux and write strobes
  function automatic logic cedt_hit(input logic [7:0] addr, input logic [7:0] ofs);
    cedt_hit = (addr == ofs);
  endfunction

  assign en            = gcfg_ff.enable;
  assign req           = i_avs_read | i_avs_write;
  assign o_ctrl_enable = en;

  // one wait state: request is answered in the cycle after it appears
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      bus_state_ff <= cedt_pkg::BUS_IDLE;
    end else begin
      case (bus_state_ff)
        cedt_pkg::BUS_IDLE: begin
          if (req) begin
            bus_state_ff <= cedt_pkg::BUS_ACK;
          end
        end
        cedt_pkg::BUS_ACK: begin
          bus_state_ff <= cedt_pkg::BUS_IDLE;
        end
        default: begin
          bus_state_ff <= cedt_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  assign o_avs_waitrequest = req & (bus_state_ff != cedt_pkg::BUS_ACK);
  assign wr_take           = i_avs_write & (bus_state_ff == cedt_pkg::BUS_ACK);
  assign eiclr             = wr_take & cedt_hit(i_avs_address, cedt_pkg::OFS_IPND)
                             & i_avs_byteenable[1] & i_avs_writedata[cedt_pkg::ERROR_INTERRUPT_PENDING_BIT];

  // read data sampled in the wait cycle, stable at the answering edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rdata_ff <= 32'h0000_0000;
    end else if (i_avs_read && bus_state_ff == cedt_pkg::BUS_IDLE) begin
      rdata_ff <= 32'h0000_0000; // unmapped offsets read as zero
      if (cedt_hit(i_avs_address, cedt_pkg::OFS_ERR_CNT)) begin
        rdata_ff <= {16'h0000, rec_ff, tec_ff}; // [RULE1]
      end
      if (cedt_hit(i_avs_address, cedt_pkg::OFS_DIAG)) begin
        rdata_ff <= {16'h0000, diag_ff}; // [RULE3]
      end
      if (cedt_hit(i_avs_address, cedt_pkg::OFS_STAMP)) begin
        rdata_ff <= {16'h0000, stamp_ff};
      end
      if (cedt_hit(i_avs_address, cedt_pkg::OFS_GCFG)) begin
        rdata_ff <= {28'h000_0000, gcfg_ff};
      end
      if (cedt_hit(i_avs_address, cedt_pkg::OFS_IPND)) begin
        rdata_ff <= {16'h0000, error_interrupt_pending_ff, 15'h0000};
      end
      if (cedt_hit(i_avs_address, cedt_pkg::OFS_IEN)) begin
        rdata_ff <= {16'h0000, error_interrupt_enable_ff, 15'h0000};
      end
    end
  end

  assign o_avs_readdata = rdata_ff;

  // global configuration; no clear on disable so contents survive low power
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      gcfg_ff <= cedt_pkg::GCFG_RST;
    end else if (wr_take && cedt_hit(i_avs_address, cedt_pkg::OFS_GCFG) && i_avs_byteenable[0]) begin
      gcfg_ff <= i_avs_writedata[cedt_pkg::GCFG_W-1:0]; // [RULE20] [RULE21]
    end
  end

  // error interrupt enable
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      error_interrupt_enable_ff <= 1'b0;
    end else if (wr_take && cedt_hit(i_avs_address, cedt_pkg::OFS_IEN) && i_avs_byteenable[1]) begin
      error_interrupt_enable_ff <= i_avs_writedata[cedt_pkg::ERROR_INTERRUPT_ENABLE_BIT];
    end
  end

  // receive pin synchroniser; first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
    end else begin
      rx_meta_ff <= i_bus_rx_pin;
      rx_sync_ff <= rx_meta_ff;
    end
  end

  // disabled controller sees a recessive bus, so a wake-up via this path is lost
  assign o_rx_bit = en ? (rx_sync_ff ^ gcfg_ff.rx_pin_polarity) : 1'b1; // [RULE19] [RULE21]

  // a receiver only pulls the bus dominant in ack slot or active error flag
  always_comb begin
    nxt_tx_logic = 1'b1;
    if (en && (i_transmitting || i_ack_slot || i_active_err_flag)) begin
      nxt_tx_logic = i_tx_bit; // [RULE12]
    end
  end

  // pin register keeps the output glitch free
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      tx_pin_ff <= 1'b1;
    end else begin
      tx_pin_ff <= nxt_tx_logic ^ gcfg_ff.tx_pin_polarity; // [RULE21]
    end
  end

  assign o_bus_tx_pin = tx_pin_ff;

  // fault confinement, simplified: no bus-off recovery sequence here
  always_comb begin
    nxt_tec     = tec_ff;
    nxt_rec     = rec_ff;
    nxt_bus_off = bus_off_ff & en;
    if (en && i_err_event) begin
      if (i_transmitting) begin
        if (tec_ff > cedt_pkg::TEC_SAT_LIMIT) begin
          nxt_tec     = cedt_pkg::CNT_MAX; // [RULE24]
          nxt_bus_off = 1'b1;
        end else begin
          nxt_tec = tec_ff + cedt_pkg::TEC_ERR_INC; // [RULE24]
        end
      end else if (rec_ff != cedt_pkg::CNT_MAX) begin
        nxt_rec = rec_ff + 8'h01; // [RULE24]
      end
    end else if (en && i_tx_ok) begin
      if (tec_ff != cedt_pkg::CNT_RST) begin
        nxt_tec = tec_ff - 8'h01; // [RULE24]
      end
    end else if (en && i_rx_ok) begin
      if (rec_ff > cedt_pkg::REC_PASSIVE) begin
        nxt_rec = cedt_pkg::REC_RESTORE; // [RULE24]
      end else if (rec_ff != cedt_pkg::CNT_RST) begin
        nxt_rec = rec_ff - 8'h01;
      end
    end
  end

  // error counters
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      tec_ff     <= cedt_pkg::CNT_RST;
      rec_ff     <= cedt_pkg::CNT_RST;
      bus_off_ff <= 1'b0;
    end else begin
      tec_ff     <= nxt_tec;
      rec_ff     <= nxt_rec;
      bus_off_ff <= nxt_bus_off;
    end
  end

  assign o_bus_off = bus_off_ff;

  // pending flag: a counter change in the clear cycle still sets it
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      error_interrupt_pending_ff <= 1'b0;
    end else if (nxt_tec != tec_ff || nxt_rec != rec_ff) begin
      error_interrupt_pending_ff <= 1'b1; // [RULE22]
    end else if (eiclr) begin
      error_interrupt_pending_ff <= 1'b0;
    end
  end

  assign o_err_irq = error_interrupt_pending_ff & error_interrupt_enable_ff; // [RULE22]

  // bit position within the current field
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pos_ff <= 6'h00;
    end else if (i_field_start) begin
      pos_ff <= 6'(i_field_len - 7'h01); // [RULE6]
    end else if (i_bit_tick) begin
      pos_ff <= pos_ff - 6'h01; // [RULE6]
    end
  end

  // diagnostic capture of the last error, pin levels as seen right now
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      diag_ff <= cedt_pkg::DIAG_RST; // [RULE2]
    end else if (en && i_err_event) begin
      diag_ff.rsvd                 <= 1'b0;
      diag_ff.drive                <= tx_pin_ff; // [RULE11]
      diag_ff.sampled_line_level   <= rx_sync_ff; // [RULE10]
      diag_ff.crc                  <= i_err_info.crc; // [RULE9]
      diag_ff.stuff                <= i_err_info.stuff; // [RULE8]
      diag_ff.was_transmitter_flag <= i_transmitting; // [RULE7]
      diag_ff.error_bit_position   <= pos_ff; // [RULE6]
      diag_ff.error_field_code     <= i_err_info.field; // [RULE4] [RULE5]
    end
  end

  // bit stamp counter, wraps freely; clear beats the increment
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      stamp_ff <= cedt_pkg::STAMP_RST; // [RULE14]
    end else if (gcfg_ff.stamp_clear_on_buf0_enable && i_buf0_xfer) begin
      stamp_ff <= cedt_pkg::STAMP_RST; // [RULE15]
    end else if (en && i_bit_tick) begin
      stamp_ff <= stamp_ff + 16'h0001; // [RULE13] [RULE23]
    end
  end

  // stamp handed to the buffer logic after a good frame
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      stamp_we_ff   <= 1'b0;
      stamp_data_ff <= cedt_pkg::STAMP_RST;
    end else begin
      stamp_we_ff <= en & (i_tx_ok | i_rx_ok); // [RULE16]
      if (en && (i_tx_ok || i_rx_ok)) begin
        stamp_data_ff <= stamp_ff; // [RULE16]
      end
    end
  end

  assign o_stamp_we   = stamp_we_ff;
  assign o_stamp_data = stamp_data_ff;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_ecnt_read;
    i_avs_read && bus_state_ff == cedt_pkg::BUS_IDLE && i_avs_address == cedt_pkg::OFS_ERR_CNT;
  endsequence

  sequence s_tx_error;
    en && i_err_event && i_transmitting && tec_ff <= cedt_pkg::TEC_SAT_LIMIT;
  endsequence

  AST_ECNT_READ: assert property (s_ecnt_read |=> o_avs_readdata == {16'h0000, $past(rec_ff), $past(tec_ff)}) // [RULE1]
    else $error("error counter read layout wrong");
  AST_DIAG_RESET: assert property ($rose(i_rst_b) |-> diag_ff == 16'h0000) // [RULE2]
    else $error("diagnostic not clear after reset");
  AST_POS_LOAD: assert property (i_field_start |=> pos_ff == 6'($past(i_field_len) - 7'h01)) // [RULE6]
    else $error("bit position load wrong");
  AST_TXE_CAPTURE: assert property (en && i_err_event |=> diag_ff.was_transmitter_flag == $past(i_transmitting)) // [RULE7]
    else $error("transmitter flag not captured");
  AST_MON_CAPTURE: assert property (en && i_err_event |=> diag_ff.sampled_line_level == $past(rx_sync_ff)) // [RULE10]
    else $error("monitor level not captured");
  AST_DRIVE_CAPTURE: assert property (en && i_err_event |=> diag_ff.drive == $past(o_bus_tx_pin)) // [RULE11]
    else $error("drive level not captured");
  AST_RX_QUIET: assert property (!i_transmitting && !i_ack_slot && !i_active_err_flag
    |=> o_bus_tx_pin == !$past(gcfg_ff.tx_pin_polarity) || $past(gcfg_ff.tx_pin_polarity) != gcfg_ff.tx_pin_polarity) // [RULE12]
    else $error("receiver drove dominant outside ack or error flag");
  AST_STAMP_INC: assert property (en && i_bit_tick && !(gcfg_ff.stamp_clear_on_buf0_enable && i_buf0_xfer)
    |=> stamp_ff == $past(stamp_ff) + 16'h0001) // [RULE13]
    else $error("stamp counter did not advance");
  AST_STAMP_CLR: assert property (gcfg_ff.stamp_clear_on_buf0_enable && i_buf0_xfer |=> stamp_ff == 16'h0000) // [RULE15]
    else $error("stamp counter not cleared on buffer 0 transfer");
  AST_STAMP_CAP: assert property (en && (i_tx_ok || i_rx_ok) |=> o_stamp_we && o_stamp_data == $past(stamp_ff)) // [RULE16]
    else $error("stamp not captured after frame");
  AST_RX_OFF: assert property (!en |-> o_rx_bit) // [RULE19]
    else $error("receive input active while disabled");
  AST_ERROR_INTERRUPT_PENDING_SET: assert property (tec_ff != $past(tec_ff) || rec_ff != $past(rec_ff) |-> error_interrupt_pending_ff ##1 (error_interrupt_pending_ff || $past(eiclr))) // [RULE22]
    else $error("counter change did not set pending flag");
  AST_TEC_STEP: assert property (s_tx_error |=> tec_ff == $past(tec_ff) + 8'h08 [*1] ##1 error_interrupt_pending_ff) // [RULE24]
    else $error("transmit error step wrong");

endmodule

// >>> cedt_pkg.sv
package cedt_pkg;

  // register byte offsets on the avalon slave
  localparam logic [7:0] OFS_ERR_CNT = 8'h00;
  localparam logic [7:0] OFS_DIAG    = 8'h04;
  localparam logic [7:0] OFS_STAMP   = 8'h08;
  localparam logic [7:0] OFS_GCFG    = 8'h0c;
  localparam logic [7:0] OFS_IPND    = 8'h10;
  localparam logic [7:0] OFS_IEN     = 8'h14;

  // global configuration bit positions
  localparam int GCFG_EN_BIT     = 0;
  localparam int GCFG_STAMP_CLEAR_ON_BUF0_ENABLE_BIT = 1;
  localparam int GCFG_TXPOL_BIT  = 2;
  localparam int GCFG_RXPOL_BIT  = 3;
  localparam int GCFG_W          = 4;

  // pending / enable bit position, pending clears by writing one
  localparam int ERROR_INTERRUPT_PENDING_BIT = 15;
  localparam int ERROR_INTERRUPT_ENABLE_BIT  = 15;

  // reset values
  localparam logic [GCFG_W-1:0] GCFG_RST  = 4'h0;
  localparam logic [15:0]       DIAG_RST  = 16'h0000;
  localparam logic [15:0]       STAMP_RST = 16'h0000;
  localparam logic [7:0]        CNT_RST   = 8'h00;

  // fault confinement figures
  localparam logic [7:0] TEC_ERR_INC    = 8'h08;
  localparam logic [7:0] TEC_SAT_LIMIT  = 8'hf7;
  localparam logic [7:0] REC_PASSIVE    = 8'h7f;
  localparam logic [7:0] REC_RESTORE    = 8'h77;
  localparam logic [7:0] CNT_MAX        = 8'hff;

  // frame field codes
  typedef enum logic [3:0] {
    FLD_ERR_FLAG   = 4'h0,
    FLD_ERR_DELIM  = 4'h1,
    FLD_ERR_ECHO   = 4'h2,
    FLD_BUS_IDLE   = 4'h3,
    FLD_ACK        = 4'h4,
    FLD_END_FRAME  = 4'h5,
    FLD_INTERMIT   = 4'h6,
    FLD_SUSPEND    = 4'h7,
    FLD_START      = 4'h8,
    FLD_ARBIT      = 4'h9,
    FLD_ID_EXT     = 4'ha,
    FLD_EXT_ARBIT  = 4'hb,
    FLD_RSVD_BITS  = 4'hc,
    FLD_LEN_CODE   = 4'hd,
    FLD_DATA       = 4'he,
    FLD_CHECKSUM   = 4'hf
  } cedt_field_type;

  // error report handed over by the frame engine
  typedef struct packed {
    cedt_field_type field;
    logic           stuff;
    logic           crc;
  } cedt_err_type;

  // diagnostic register layout, msb first
  typedef struct packed {
    logic           rsvd;
    logic           drive;
    logic           sampled_line_level;
    logic           crc;
    logic           stuff;
    logic           was_transmitter_flag;
    logic [5:0]     error_bit_position;
    cedt_field_type error_field_code;
  } cedt_diag_type;

  // software configuration
  typedef struct packed {
    logic rx_pin_polarity;
    logic tx_pin_polarity;
    logic stamp_clear_on_buf0_enable;
    logic enable;
  } cedt_gcfg_type;

  // bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } cedt_bus_type;

endpackage

// >>> cedt_tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // clock, reset and avalon master
  logic                   clk;
  logic                   rst_b;
  logic [7:0]             adr;
  logic                   rd, wr;
  logic [31:0]            wdat, rdat;
  logic                   wreq;
  // engine events: tick, field start, error, tx ok, rx ok, buffer 0
  logic [5:0]             pls;
  logic [6:0]             flen;
  cedt_pkg::cedt_err_type einfo;
  logic                   txing, txbit, ack, aef;
  // design results and pins
  logic                   rxbit, en, boff, swe, irq, rx_pin, tx_pin;
  logic [15:0]            sdat;
  // far side controls
  logic                   pol_tx, pol_rx, odom;
  int                     fail_count, compares;

  cedt_core i_cedt_core (
    .i_clk(clk), .i_rst_b(rst_b),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_bit_tick(pls[0]), .i_field_start(pls[1]), .i_field_len(flen), .i_err_event(pls[2]),
    .i_err_info(einfo), .i_transmitting(txing), .i_tx_bit(txbit), .i_ack_slot(ack),
    .i_active_err_flag(aef), .i_tx_ok(pls[3]), .i_rx_ok(pls[4]), .i_buf0_xfer(pls[5]),
    .o_rx_bit(rxbit), .o_ctrl_enable(en), .o_bus_off(boff), .o_stamp_we(swe),
    .o_stamp_data(sdat), .o_err_irq(irq), .i_bus_rx_pin(rx_pin), .o_bus_tx_pin(tx_pin)
  );

  cedt_can_node i_cedt_can_node (
    .i_tx_pin(tx_pin), .o_rx_pin(rx_pin), .i_tx_inv(pol_tx), .i_rx_inv(pol_rx), .i_other_dom(odom)
  );

  // 50 mhz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // one read; request held until waitrequest is seen low at an edge
  task automatic avs_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd  <= 1'b1;
    adr <= a;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    d = rdat;
    rd <= 1'b0;
  endtask

  // one write, same handshake
  task automatic avs_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr   <= 1'b1;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    wr <= 1'b0;
  endtask

  // register value compare
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // single pin compare
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    avs_rd(a, d);
    chk_reg(d, exp);
  endtask

  // raise the chosen event strobes for n cycles
  task automatic pulse(input logic [5:0] m, input int n);
    repeat (n) @(posedge clk) pls <= m;
    @(posedge clk) pls <= 6'h00;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // expected diagnostic word, msb first
  function automatic logic [31:0] dg(logic dr, logic mo, logic cr, logic st, logic tx,
                                     logic [5:0] p, logic [3:0] f);
    return {16'h0000, 1'b0, dr, mo, cr, st, tx, p, f};
  endfunction

  task automatic test_done(input string name);
    $display("test %s finished, fails so far %0d", name, fail_count);
  endtask

  task automatic end_of_test;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog sized well above the long stamp wrap run
  initial begin
    repeat (99000) @(posedge clk);
    fail_count++;
    $display("watchdog expired at %0t", $time);
    end_of_test;
  end

  // main sequence
  initial begin
    rst_b = 1'b0; adr = 8'h00; rd = 1'b0; wr = 1'b0; wdat = 32'h0; pls = 6'h00; flen = 7'h00;
    einfo = '0; txing = 1'b0; txbit = 1'b1; ack = 1'b0; aef = 1'b0;
    pol_tx = 1'b0; pol_rx = 1'b0; odom = 1'b0; fail_count = 0; compares = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    // reset values, read-only places, unmapped address
    rd_chk(cedt_pkg::OFS_ERR_CNT, 32'h0);
    rd_chk(cedt_pkg::OFS_DIAG, 32'h0);
    rd_chk(cedt_pkg::OFS_STAMP, 32'h0);
    avs_wr(cedt_pkg::OFS_ERR_CNT, 32'h0000ffff);
    avs_wr(cedt_pkg::OFS_DIAG, 32'h0000ffff);
    rd_chk(cedt_pkg::OFS_ERR_CNT, 32'h0);
    rd_chk(cedt_pkg::OFS_DIAG, 32'h0);
    rd_chk(8'h1c, 32'h0);
    test_done("reset");
    // transmitter error at bit position 5 of the ack field
    avs_wr(cedt_pkg::OFS_GCFG, 32'h1);
    @(posedge clk) begin
      txing <= 1'b1; txbit <= 1'b0; flen <= 7'h08; einfo <= '{cedt_pkg::FLD_ACK, 1'b0, 1'b1};
    end
    cyc(4);
    pulse(6'h02, 1);
    pulse(6'h01, 2);
    pulse(6'h04, 1);
    rd_chk(cedt_pkg::OFS_DIAG, dg(0, 0, 1, 0, 1, 6'h05, 4'h4));
    rd_chk(cedt_pkg::OFS_ERR_CNT, 32'h00000008);
    chk_bit(boff, 1'b0);
    rd_chk(cedt_pkg::OFS_IPND, 32'h00008000);
    chk_bit(irq, 1'b0);
    avs_wr(cedt_pkg::OFS_IEN, 32'h00008000);
    cyc(1);
    chk_bit(irq, 1'b1);
    avs_wr(cedt_pkg::OFS_IPND, 32'h00008000);
    rd_chk(cedt_pkg::OFS_IPND, 32'h0);
    chk_bit(irq, 1'b0);
    test_done("transmit error");
    // receiver errors walking every field code, other node pulls the bus low
    @(posedge clk) begin
      txing <= 1'b0; txbit <= 1'b1; odom <= 1'b1;
    end
    cyc(4);
    for (int f = 0; f < 16; f++) begin
      @(posedge clk) begin
        flen <= 7'(f + 1); einfo <= '{cedt_pkg::cedt_field_type'(f[3:0]), f[0], f[1]};
      end
      pulse(6'h02, 1);
      pulse(6'h04, 1);
      rd_chk(cedt_pkg::OFS_DIAG, dg(1, 0, f[1], f[0], 0, 6'(f), 4'(f)));
    end
    rd_chk(cedt_pkg::OFS_ERR_CNT, 32'h00001008);
    test_done("receive errors");
    // stamp counting, buffer 0 clear, capture on good frame, wrap
    avs_wr(cedt_pkg::OFS_GCFG, 32'h3);
    pulse(6'h20, 1);
    pulse(6'h01, 10);
    rd_chk(cedt_pkg::OFS_STAMP, 32'h0000000a);
    pulse(6'h08, 1);
    for (int n = 0; n < 4 && swe !== 1'b1; n++) @(posedge clk);
    chk_bit(swe, 1'b1);
    chk_reg({16'h0000, sdat}, 32'h0000000a);
    @(posedge clk);
    chk_bit(swe, 1'b0);
    pulse(6'h10, 1);
    rd_chk(cedt_pkg::OFS_ERR_CNT, 32'h00000f07);
    avs_wr(cedt_pkg::OFS_GCFG, 32'h1);
    pulse(6'h20, 1);
    rd_chk(cedt_pkg::OFS_STAMP, 32'h0000000a);
    avs_wr(cedt_pkg::OFS_GCFG, 32'h3);
    pulse(6'h20, 1);
    pulse(6'h01, 65537);
    rd_chk(cedt_pkg::OFS_STAMP, 32'h00000001);
    test_done("time stamp");
    // receiver drive, pin polarity, disable and re-enable
    @(posedge clk) begin
      odom <= 1'b0; txbit <= 1'b0;
    end
    cyc(3);
    chk_bit(tx_pin, 1'b1);
    @(posedge clk) ack <= 1'b1;
    cyc(3);
    chk_bit(tx_pin, 1'b0);
    @(posedge clk) begin
      ack <= 1'b0; aef <= 1'b1;
    end
    cyc(3);
    chk_bit(tx_pin, 1'b0);
    @(posedge clk) begin
      aef <= 1'b0; txbit <= 1'b1; pol_tx <= 1'b1; pol_rx <= 1'b1; odom <= 1'b1;
    end
    avs_wr(cedt_pkg::OFS_GCFG, 32'h0000000d);
    cyc(4);
    chk_bit(tx_pin, 1'b0);
    chk_bit(rxbit, 1'b0);
    avs_wr(cedt_pkg::OFS_GCFG, 32'h0000000c);
    cyc(4);
    chk_bit(rxbit, 1'b1);
    chk_bit(en, 1'b0);
    rd_chk(cedt_pkg::OFS_GCFG, 32'h0000000c);
    avs_wr(cedt_pkg::OFS_GCFG, 32'h0000000d);
    cyc(4);
    chk_bit(en, 1'b1);
    chk_bit(rxbit, 1'b0);
    test_done("pins");
    end_of_test;
  end
endmodule
